/* File: logic/sscl_top.sv */
// Chosen here: the register offset and the plain strobed port.
`timescale 1ns/1ps
module sscl_top
  import sscl_pkg::*;
#(
  parameter int SETTLE_CYCLES = SSCL_SETTLE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        cardAccess,
  input  wire logic        powerRequest,
  input  wire logic        powerUp,
  input  wire logic        probeBusy,
  input  wire logic        legacyMode,
  input  wire logic        legacyAutoSwitch,
  input  wire logic        cardIsCardbus,
  input  wire logic        cardIdle,
  input  wire logic        cardClockStopped,
  input  wire logic        cardParityError,
  input  wire logic        pinsCentralDma,
  input  wire logic        clockStopRequest,
  input  wire logic        ringIndicateOut,
  input  wire logic        wakeEvent,
  input  wire logic        idWriteRequest,
  output logic             switchData,
  output logic             autoSwitchActive,
  output logic             cardFsmClockEn,
  output logic             idRegsWriteEn,
  output logic             sysErrOut,
  output logic             centralDmaActive,
  output logic             vcc5Select,
  output logic             clockStopGrant,
  output logic             sharedPinOut
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic       rstLocal_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstLocal_n = rstSync_q[1];

  // ------------------------------------------------------------
  // register and status state
  // ------------------------------------------------------------
  logic [7:0]     ctrl_q, ctrl_d;
  logic           activity_q, activity_d;
  logic           stream_q, stream_d;
  logic           upPend_q, upPend_d;
  logic           downPend_q, downPend_d;
  logic           probe_q, probe_d;
  logic           dirUp_q, dirUp_d;
  logic [15:0]    shift_q, shift_d;
  logic [4:0]     bitCnt_q, bitCnt_d;
  logic [15:0]    settle_q, settle_d;
  sscl_state_type state_q, state_d;
  logic [31:0]    rdata_d;
  logic           hit;
  logic [13:0]    regView;
  logic [8:0]     out_d, out_q;

  assign hit = (regAddr == SSCL_SYSCTL_OFFSET);
  always_comb begin
    regView = {activity_q, 1'b1, stream_q, upPend_q, downPend_q, probe_q, ctrl_q};
  end

  always_comb begin
    ctrl_d     = ctrl_q;
    activity_d = activity_q;
    probe_d    = probeBusy;
    rdata_d    = 32'h0000_0000;
    if (regWrite && hit) begin
      ctrl_d = regWdata[7:0] & SSCL_WRITE_MASK[7:0];
    end
    if (regRead && hit) begin
      rdata_d = {18'h00000, regView};
    end
    if (regRead && hit) begin
      activity_d = 1'b0;
    end
    if (cardAccess) begin
      activity_d = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // power switch stream
  // ------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    shift_d    = shift_q;
    bitCnt_d   = bitCnt_q;
    settle_d   = settle_q;
    dirUp_d    = dirUp_q;
    stream_d   = stream_q;
    upPend_d   = upPend_q;
    downPend_d = downPend_q;
    case (state_q)
      SSCL_IDLE: begin
        if (powerRequest) begin
          state_d  = SSCL_SHIFT;
          stream_d = 1'b1;
          dirUp_d  = powerUp;
          shift_d  = {14'h0000, powerUp, ctrl_q[SSCL_VCC_BIT]};
          bitCnt_d = 5'(SSCL_STREAM_BITS);
        end
      end
      SSCL_SHIFT: begin
        shift_d  = {1'b0, shift_q[15:1]};
        bitCnt_d = bitCnt_q - 5'h01;
        if (bitCnt_q == 5'h01) begin
          state_d  = SSCL_SETTLE;
          settle_d = 16'(SETTLE_CYCLES);
          upPend_d   = dirUp_q;
          downPend_d = !dirUp_q;
        end
      end
      SSCL_SETTLE: begin
        settle_d = settle_q - 16'h0001;
        if (settle_q == 16'h0001) begin
          state_d = SSCL_DONE;
        end
      end
      SSCL_DONE: begin
        stream_d   = 1'b0;
        upPend_d   = 1'b0;
        downPend_d = 1'b0;
        state_d    = SSCL_IDLE;
      end
      default: begin
        state_d = SSCL_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  always_comb begin
    out_d = '0;
    out_d[0] = (state_q == SSCL_SHIFT) ? shift_q[0] : 1'b0;
    out_d[1] = ctrl_q[SSCL_AUTO_SW_BIT] & legacyAutoSwitch;
    out_d[2] = !(ctrl_q[SSCL_GATE_BIT] & cardIsCardbus & cardIdle & cardClockStopped);
    out_d[3] = idWriteRequest & !ctrl_q[SSCL_LOCK_BIT];
    out_d[4] = cardParityError & ctrl_q[SSCL_PARITY_BIT];
    out_d[5] = ctrl_q[SSCL_DMA_BIT] & pinsCentralDma;
    out_d[6] = legacyMode & ctrl_q[SSCL_VCC_BIT];
    out_d[7] = clockStopRequest & !ctrl_q[SSCL_KEEP_BIT];
    out_d[8] = ctrl_q[SSCL_SHARE_BIT] ? wakeEvent : (ringIndicateOut | wakeEvent);
  end

  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      ctrl_q     <= SSCL_RESET_VALUE[7:0];
      activity_q <= 1'b0;
      probe_q    <= 1'b0;
      regRdata   <= 32'h0000_0000;
      state_q    <= SSCL_IDLE;
      shift_q    <= 16'h0000;
      bitCnt_q   <= 5'h00;
      settle_q   <= 16'h0000;
      dirUp_q    <= 1'b0;
      stream_q   <= 1'b0;
      upPend_q   <= 1'b0;
      downPend_q <= 1'b0;
      out_q      <= 9'h004;
    end else begin
      ctrl_q     <= ctrl_d;
      activity_q <= activity_d;
      probe_q    <= probe_d;
      regRdata   <= rdata_d;
      state_q    <= state_d;
      shift_q    <= shift_d;
      bitCnt_q   <= bitCnt_d;
      settle_q   <= settle_d;
      dirUp_q    <= dirUp_d;
      stream_q   <= stream_d;
      upPend_q   <= upPend_d;
      downPend_q <= downPend_d;
      out_q      <= out_d;
    end
  end

  assign switchData       = out_q[0];
  assign autoSwitchActive = out_q[1];
  assign cardFsmClockEn   = out_q[2];
  assign idRegsWriteEn    = out_q[3];
  assign sysErrOut        = out_q[4];
  assign centralDmaActive = out_q[5];
  assign vcc5Select       = out_q[6];
  assign clockStopGrant   = out_q[7];
  assign sharedPinOut     = out_q[8];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence readHit_s;
    regRead && hit && !cardAccess;
  endsequence
  activity_clear_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    readHit_s |=> !activity_q) else $error("activity flag not cleared by read");
  activity_set_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    cardAccess |=> activity_q) else $error("activity flag not set");
  rsvd_one_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    regRead && hit |=> regRdata[12]) else $error("bit 12 not one");
  stream_hold_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    (state_q == SSCL_SHIFT || state_q == SSCL_SETTLE) |-> stream_q)
    else $error("stream flag dropped early");
  up_settle_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    (state_q == SSCL_SETTLE && dirUp_q) |-> upPend_q && !downPend_q)
    else $error("power-up settle flag wrong");
  down_settle_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    (state_q == SSCL_SETTLE && !dirUp_q) |-> downPend_q && !upPend_q)
    else $error("power-down settle flag wrong");
  probe_track_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    probeBusy |=> probe_q) else $error("probe flag not set");
  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    regWrite && hit |=> ctrl_q == 8'($past(regWdata))) else $error("control write lost");
  clock_keep_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    ctrl_q[SSCL_KEEP_BIT] |=> !clockStopGrant) else $error("clock stop granted");
  share_pin_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    !ctrl_q[SSCL_SHARE_BIT] && ringIndicateOut |=> sharedPinOut)
    else $error("ring indicate lost on shared pin");

  // ------------------------------------------------------------
  // stream, status and output checks
  // ------------------------------------------------------------
  sequence shiftLast_s;
    state_q == SSCL_SHIFT && bitCnt_q == 5'h01;
  endsequence
  sequence settleSteady_s;
    state_q == SSCL_SETTLE && stream_q && (upPend_q ^ downPend_q);
  endsequence
  // a read or card access in the same cycle may move the flag
  sequence writeOnly_s;
    regWrite && hit && !regRead && !cardAccess;
  endsequence
  stream_start_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    state_q == SSCL_IDLE && powerRequest |=> stream_q) else $error("stream flag not raised");
  settle_enter_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    shiftLast_s |=> settleSteady_s) else $error("settle phase not entered");
  settle_end_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    state_q == SSCL_DONE |=> !stream_q && !upPend_q && !downPend_q)
    else $error("power flags not cleared");
  status_write_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    writeOnly_s |=> $stable(activity_q)) else $error("write changed activity flag");
  probe_clear_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    !probeBusy |=> !probe_q) else $error("probe flag not cleared");
  auto_switch_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    !ctrl_q[SSCL_AUTO_SW_BIT] |=> !autoSwitchActive) else $error("auto switch not gated");
  clock_gate_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    ctrl_q[SSCL_GATE_BIT] && cardIsCardbus && cardIdle && cardClockStopped |=> !cardFsmClockEn)
    else $error("idle card still clocked");
  id_lock_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    ctrl_q[SSCL_LOCK_BIT] |=> !idRegsWriteEn) else $error("locked id registers writable");
  parity_route_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    ctrl_q[SSCL_PARITY_BIT] && cardParityError |=> sysErrOut)
    else $error("parity error not reported");
  parity_block_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    !ctrl_q[SSCL_PARITY_BIT] |=> !sysErrOut) else $error("parity error reported while off");
  dma_gate_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    !ctrl_q[SSCL_DMA_BIT] |=> !centralDmaActive) else $error("central dma not gated");
  legacy_vcc_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    !legacyMode |=> !vcc5Select) else $error("supply select outside legacy mode");
  wake_only_a: assert property (@(posedge sys_clk) disable iff (!rstLocal_n)
    ctrl_q[SSCL_SHARE_BIT] && !wakeEvent |=> !sharedPinOut)
    else $error("ring indicate on wake-only pin");
endmodule : sscl_top

/* File: logic/sscl_pkg.sv */
package sscl_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  SSCL_SYSCTL_OFFSET = 8'h80;
  localparam logic [13:0] SSCL_RESET_VALUE   = 14'h1060;
  localparam logic [13:0] SSCL_WRITE_MASK    = 14'h00FF;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SSCL_ACTIVITY_BIT   = 13;
  localparam int SSCL_RSVD_ONE_BIT   = 12;
  localparam int SSCL_STREAM_BIT     = 11;
  localparam int SSCL_UP_BIT         = 10;
  localparam int SSCL_DOWN_BIT       = 9;
  localparam int SSCL_PROBE_BIT      = 8;
  localparam int SSCL_AUTO_SW_BIT    = 7;
  localparam int SSCL_GATE_BIT       = 6;
  localparam int SSCL_LOCK_BIT       = 5;
  localparam int SSCL_PARITY_BIT     = 4;
  localparam int SSCL_DMA_BIT        = 3;
  localparam int SSCL_VCC_BIT        = 2;
  localparam int SSCL_KEEP_BIT       = 1;
  localparam int SSCL_SHARE_BIT      = 0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SSCL_CLK_MHZ        = 40;
  localparam int SSCL_SETTLE_US      = 100;
  localparam int SSCL_SETTLE_CYCLES  = SSCL_SETTLE_US * SSCL_CLK_MHZ;
  localparam int SSCL_STREAM_BITS    = 16;
  typedef enum logic [3:0] {
    SSCL_IDLE   = 4'b0001,
    SSCL_SHIFT  = 4'b0010,
    SSCL_SETTLE = 4'b0100,
    SSCL_DONE   = 4'b1000
  } sscl_state_type;
endpackage : sscl_pkg

/* File: bench/sscl_host.sv */
`timescale 1ns/1ps
module sscl_host (
  input  wire logic        sys_clk,
  output logic      [7:0]  regAddr,
  output logic      [31:0] regWdata,
  output logic             regWrite,
  output logic             regRead
);
  logic [31:0] expQ[$];
  initial begin
    regAddr  = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end
  // released bus shows inverted values so stale data never decodes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
  endtask : rd
endmodule : sscl_host

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, r;
  logic        regWrite, regRead, rdSeen = 1'b0;
  logic        cardAccess = 1'b0, powerRequest = 1'b0, powerUp = 1'b0, probeBusy = 1'b0;
  logic [10:0] lv = 11'h000;
  logic [7:0]  ctl;
  wire  [7:0]  outs;
  wire         streamBit;
  int          num_errors = 0, samples_checked = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  sscl_host i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead));
  sscl_top #(.SETTLE_CYCLES(8)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .cardAccess(cardAccess), .powerRequest(powerRequest), .powerUp(powerUp),
    .probeBusy(probeBusy), .legacyMode(lv[10]), .legacyAutoSwitch(lv[9]),
    .cardIsCardbus(lv[8]), .cardIdle(lv[7]), .cardClockStopped(lv[6]),
    .cardParityError(lv[5]), .pinsCentralDma(lv[4]), .clockStopRequest(lv[3]),
    .ringIndicateOut(lv[2]), .wakeEvent(lv[1]), .idWriteRequest(lv[0]),
    .switchData(streamBit), .autoSwitchActive(outs[7]), .cardFsmClockEn(outs[6]),
    .idRegsWriteEn(outs[5]), .sysErrOut(outs[4]), .centralDmaActive(outs[3]),
    .vcc5Select(outs[2]), .clockStopGrant(outs[1]), .sharedPinOut(outs[0]));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("errors=%0d checked=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // read monitor and timeout
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rdSeen) check(regRdata, i_host.expQ.pop_front());
    rdSeen <= regRead;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(13));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    i_host.rd(8'h80, 32'h0000_1060);
    i_host.wr(8'h80, 32'hFFFF_FFFF);
    i_host.rd(8'h80, 32'h0000_10FF);
    i_host.wr(8'h80, 32'h0000_0000);
    i_host.rd(8'h80, 32'h0000_1000);
    i_host.rd(8'h84, 32'h0000_0000);
    // set by access, cleared by read, not by write
    @(posedge sys_clk) cardAccess <= 1'b1;
    @(posedge sys_clk) cardAccess <= 1'b0;
    i_host.wr(8'h80, 32'h0000_0000);
    i_host.rd(8'h80, 32'h0000_3000);
    i_host.rd(8'h80, 32'h0000_1000);
    @(posedge sys_clk) probeBusy <= 1'b1;
    i_host.rd(8'h80, 32'h0000_1100);
    @(posedge sys_clk) probeBusy <= 1'b0;
    // stream then settle then clear
    // supply bit set so the first stream bit is not trivially zero
    i_host.wr(8'h80, 32'h0000_0004);
    for (int u = 0; u < 2; u++) begin
      @(posedge sys_clk);
      powerUp <= u[0];
      powerRequest <= 1'b1;
      @(posedge sys_clk) powerRequest <= 1'b0;
      @(posedge sys_clk);
      #1 check({31'h0, streamBit}, 32'h0000_0001);
      @(posedge sys_clk);
      #1 check({31'h0, streamBit}, {31'h0, u[0]});
      i_host.rd(8'h80, 32'h0000_1804);
      repeat (13) @(posedge sys_clk);
      i_host.rd(8'h80, u[0] ? 32'h0000_1C04 : 32'h0000_1A04);
      repeat (20) @(posedge sys_clk);
      i_host.rd(8'h80, 32'h0000_1004);
    end
    // random control bytes against random side inputs
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      ctl = r[7:0];
      i_host.wr(8'h80, r);
      i_host.rd(8'h80, {24'h000010, ctl});
      @(posedge sys_clk) lv <= r[18:8];
      repeat (3) @(posedge sys_clk);
      #1;
      check({24'h0, outs}, {24'h0, ctl[7] & lv[9], !(ctl[6] & lv[8] & lv[7] & lv[6]),
        lv[0] & !ctl[5], lv[5] & ctl[4], ctl[3] & lv[4], lv[10] & ctl[2],
        lv[3] & !ctl[1], ctl[0] ? lv[1] : (lv[2] | lv[1])});
    end
    repeat (3) @(posedge sys_clk);
    final_report();
  end
endmodule : tb_top
